/* File: bcc_pkg.sv */
// Package: register map, field positions, reset values for the bus controller control block
package bcc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_OWN_ADDR = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h30;
	localparam logic [7:0] OFS_IRQ_RAW = 8'h34;
	localparam logic [7:0] OFS_ENABLE = 8'h6c;

	////////////////////////////////////////////////////////////////////////////////
	// Control word fields
	localparam int B_MASTER_EN = 0;
	localparam int B_SPEED_LO = 1;
	localparam int B_SPEED_HI = 2;
	localparam int B_INIT_WIDE = 4;
	localparam int B_TGT_WIDE = 3;
	localparam int B_RESTART = 5;
	localparam int B_TGT_OFF = 6;
	localparam int B_STOP_ADDR = 7;
	localparam int B_TXE_CTRL = 8;
	localparam int B_RX_HOLD = 9;
	localparam int B_STOP_MALW = 10;
	localparam int CTRL_W = 11;

	// Bits software may change (0..9); 10 and above are read-only or reserved
	localparam logic [CTRL_W-1:0] CTRL_WMASK = 11'h3ff;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h065;

	////////////////////////////////////////////////////////////////////////////////
	// Speed codes
	localparam logic [1:0] SPD_STD = 2'h1;
	localparam logic [1:0] SPD_FAST = 2'h2;
	localparam logic [1:0] SPD_HIGH = 2'h3;
	localparam logic [1:0] SPD_MAX = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt status layout
	localparam int IRQ_W = 10;
	localparam int I_RX_OVER = 1;
	localparam int I_TX_EMPTY = 4;
	localparam int I_TX_ABORT = 6;
	localparam int I_STOP = 9;
	localparam logic [IRQ_W-1:0] IRQ_USED = 10'h252;

	////////////////////////////////////////////////////////////////////////////////
	// Other widths and resets
	localparam int ADDR_W = 10;
	localparam int SEVEN = 7;
	localparam logic [ADDR_W-1:0] OWN_ADDR_RESET = 10'h055;
	localparam logic [IRQ_W-1:0] MASK_RESET = 10'h000;

endpackage

/* File: bcc_ctrl.sv */
// Module: bus controller control word with role, addressing and interrupt qualification logic
`timescale 1ns/100ps
//
// Contract
// - Control word writes accepted only while controller enable reads zero.
// - Bits 10, 11, 16 to 19 are read-only to software.
// - Bit 10 reads zero: master stop interrupt only while master busy.
// - Bit 9 chooses overflow or bus hold when receive queue is full.
// - Bit 8 chooses plain or controlled transmit-empty interrupt.
// - Bit 7 set limits slave stop interrupt to addressed transfers.
// - General call never qualifies stop interrupt when bit 7 set.
// - Bit 6 resets to one and disables all slave actions.
// - Bit 5 resets to one and permits repeated starts as master.
// - Forbidden operation with repeated start off sets abort flag bit 6.
// - Combined operation with repeated start off splits into stop then start.
// - Bit 4 selects seven or ten bit addresses as master.
// - Bit 3 clear: slave ignores wide addresses, compares low seven bits.
// - Bit 3 set: slave answers only wide addresses matching all ten bits.
// - Speed field resets to two; illegal values become highest supported speed.
// - Bit 0 resets to one and enables the master function.

module bcc_ctrl (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Bus events from the line engine
	input  wire logic        stop_seen,
	input  wire logic        master_busy,
	input  wire logic        addr_seen,
	input  wire logic        addr_is_wide,
	input  wire logic [9:0]  addr_value,
	input  wire logic        addr_general_call,
	// Queue state
	input  wire logic        rx_push,
	input  wire logic        rx_queue_full,
	input  wire logic        tx_queue_empty,
	input  wire logic        tx_idle,
	// Master operation requests
	input  wire logic        op_req,
	input  wire logic        op_start_byte,
	input  wire logic        op_high_speed,
	input  wire logic        op_wide_read,
	input  wire logic        op_combined,
	// Role and mode outputs
	output logic             master_on,
	output logic             target_on,
	output logic      [1:0]  speed_sel,
	output logic             initiator_wide,
	output logic             hold_bus,
	output logic             target_match,
	output logic             op_accept,
	output logic             op_split,
	output logic             op_restart,
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////////////
	// State
	logic [bcc_pkg::CTRL_W-1:0] ctrl_reg;
	logic [bcc_pkg::CTRL_W-1:0] ctrl_next;
	logic                       enable_reg;
	logic [bcc_pkg::ADDR_W-1:0] own_addr_reg;
	logic [bcc_pkg::IRQ_W-1:0]  raw_reg;
	logic [bcc_pkg::IRQ_W-1:0]  raw_next;
	logic [bcc_pkg::IRQ_W-1:0]  mask_reg;
	logic                       addressed_reg;
	logic [31:0]                rdata_reg;
	logic [31:0]                rdata_next;
	logic                       master_on_reg;
	logic                       target_on_reg;
	logic                       hold_reg;
	logic                       match_reg;
	logic                       accept_reg;
	logic                       split_reg;
	logic                       restart_reg;
	logic                       irq_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode
	wire hit_ctrl = reg_addr == bcc_pkg::OFS_CONTROL;
	wire hit_own = reg_addr == bcc_pkg::OFS_OWN_ADDR;
	wire hit_mask = reg_addr == bcc_pkg::OFS_IRQ_MASK;
	wire hit_raw = reg_addr == bcc_pkg::OFS_IRQ_RAW;
	wire hit_en = reg_addr == bcc_pkg::OFS_ENABLE;

	wire wr_ctrl = reg_wr && hit_ctrl && !enable_reg;
	wire wr_own = reg_wr && hit_own && !enable_reg;
	wire wr_mask = reg_wr && hit_mask;
	wire wr_raw = reg_wr && hit_raw;
	wire wr_en = reg_wr && hit_en;

	////////////////////////////////////////////////////////////////////////////////
	// Control fields
	wire f_master = ctrl_reg[bcc_pkg::B_MASTER_EN];
	wire [1:0] f_speed = ctrl_reg[bcc_pkg::B_SPEED_HI:bcc_pkg::B_SPEED_LO];
	wire f_tgt_wide = ctrl_reg[bcc_pkg::B_TGT_WIDE];
	wire f_init_wide = ctrl_reg[bcc_pkg::B_INIT_WIDE];
	wire f_restart = ctrl_reg[bcc_pkg::B_RESTART];
	wire f_tgt_off = ctrl_reg[bcc_pkg::B_TGT_OFF];
	wire f_stop_addr = ctrl_reg[bcc_pkg::B_STOP_ADDR];
	wire f_txe_ctrl = ctrl_reg[bcc_pkg::B_TXE_CTRL];
	wire f_rx_hold = ctrl_reg[bcc_pkg::B_RX_HOLD];
	wire f_stop_malw = ctrl_reg[bcc_pkg::B_STOP_MALW];

	////////////////////////////////////////////////////////////////////////////////
	// Speed sanitising of written value
	wire [1:0] w_speed = reg_wdata[bcc_pkg::B_SPEED_HI:bcc_pkg::B_SPEED_LO];
	wire spd_bad = (w_speed == 2'h0) || (w_speed > bcc_pkg::SPD_MAX);
	wire [1:0] w_speed_ok = spd_bad ? bcc_pkg::SPD_MAX : w_speed;

	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl) begin
			// Read-only and reserved positions keep their value
			ctrl_next = (ctrl_reg & ~bcc_pkg::CTRL_WMASK)
				| (reg_wdata[bcc_pkg::CTRL_W-1:0] & bcc_pkg::CTRL_WMASK);
			ctrl_next[bcc_pkg::B_SPEED_HI:bcc_pkg::B_SPEED_LO] = w_speed_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Roles
	wire master_live = enable_reg && f_master;
	wire target_live = enable_reg && !f_tgt_off;

	////////////////////////////////////////////////////////////////////////////////
	// Slave address compare
	wire [6:0] own_low = own_addr_reg[bcc_pkg::SEVEN-1:0];
	wire [6:0] in_low = addr_value[bcc_pkg::SEVEN-1:0];
	wire match_narrow = !f_tgt_wide && !addr_is_wide && (in_low == own_low);
	wire match_wide = f_tgt_wide && addr_is_wide && (addr_value == own_addr_reg);
	wire addr_match = addr_seen && target_live && !addr_general_call
		&& (match_narrow || match_wide);

	////////////////////////////////////////////////////////////////////////////////
	// Stop interrupt qualification
	wire stop_slave = target_live && (!f_stop_addr || addressed_reg);
	wire stop_master = master_live && (master_busy || f_stop_malw);
	wire ev_stop = stop_seen && (stop_slave || stop_master);

	////////////////////////////////////////////////////////////////////////////////
	// Receive queue full handling
	wire ev_rx_over = rx_push && rx_queue_full && !f_rx_hold && enable_reg;
	wire hold_want = rx_queue_full && f_rx_hold && enable_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Transmit empty: controlled mode waits for the line to go idle
	wire ev_tx_empty = enable_reg && tx_queue_empty
		&& (!f_txe_ctrl || tx_idle);

	////////////////////////////////////////////////////////////////////////////////
	// Master operation screening
	wire op_forbid = op_start_byte || op_high_speed || op_wide_read;
	wire op_go = op_req && master_live;
	wire ev_abort = op_go && !f_restart && op_forbid;
	wire op_ok = op_go && !ev_abort;
	wire do_split = op_ok && op_combined && !f_restart;
	wire do_restart = op_ok && op_combined && f_restart;

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt status: events set, write one clears, set wins
	logic [bcc_pkg::IRQ_W-1:0] ev_vec;
	logic [bcc_pkg::IRQ_W-1:0] clr_vec;

	always_comb begin
		ev_vec = '0;
		ev_vec[bcc_pkg::I_RX_OVER] = ev_rx_over;
		ev_vec[bcc_pkg::I_TX_EMPTY] = ev_tx_empty;
		ev_vec[bcc_pkg::I_TX_ABORT] = ev_abort;
		ev_vec[bcc_pkg::I_STOP] = ev_stop;
	end

	assign clr_vec = wr_raw ? reg_wdata[bcc_pkg::IRQ_W-1:0] : '0;

	always_comb begin
		raw_next = ((raw_reg & ~clr_vec) | ev_vec) & bcc_pkg::IRQ_USED;
	end

	wire irq_next = |(raw_next & mask_reg);

	////////////////////////////////////////////////////////////////////////////////
	// Read mux, unmapped addresses read zero
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (reg_rd) begin
			if (hit_ctrl) begin
				rdata_next[bcc_pkg::CTRL_W-1:0] = ctrl_reg;
			end
			if (hit_own) begin
				rdata_next[bcc_pkg::ADDR_W-1:0] = own_addr_reg;
			end
			if (hit_mask) begin
				rdata_next[bcc_pkg::IRQ_W-1:0] = mask_reg;
			end
			if (hit_raw) begin
				rdata_next[bcc_pkg::IRQ_W-1:0] = raw_reg;
			end
			if (hit_en) begin
				rdata_next[0] = enable_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control and configuration registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= bcc_pkg::CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			enable_reg <= 1'b0;
			own_addr_reg <= bcc_pkg::OWN_ADDR_RESET;
			mask_reg <= bcc_pkg::MASK_RESET;
		end else begin
			if (wr_en) begin
				enable_reg <= reg_wdata[0];
			end
			if (wr_own) begin
				own_addr_reg <= reg_wdata[bcc_pkg::ADDR_W-1:0];
			end
			if (wr_mask) begin
				mask_reg <= reg_wdata[bcc_pkg::IRQ_W-1:0] & bcc_pkg::IRQ_USED;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Addressed flag: set on own match, cleared by stop
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			addressed_reg <= 1'b0;
		end else if (addr_match) begin
			addressed_reg <= 1'b1;
		end else if (stop_seen || !target_live) begin
			addressed_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt status and read data
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			raw_reg <= '0;
			irq_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			raw_reg <= raw_next;
			irq_reg <= irq_next;
			rdata_reg <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			master_on_reg <= 1'b0;
			target_on_reg <= 1'b0;
			hold_reg <= 1'b0;
			match_reg <= 1'b0;
		end else begin
			master_on_reg <= master_live;
			target_on_reg <= target_live;
			hold_reg <= hold_want;
			match_reg <= addr_match;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			accept_reg <= 1'b0;
			split_reg <= 1'b0;
			restart_reg <= 1'b0;
		end else begin
			accept_reg <= op_ok;
			split_reg <= do_split;
			restart_reg <= do_restart;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Port drive
	assign reg_rdata = rdata_reg;
	assign master_on = master_on_reg;
	assign target_on = target_on_reg;
	assign speed_sel = ctrl_reg[bcc_pkg::B_SPEED_HI:bcc_pkg::B_SPEED_LO];
	assign initiator_wide = ctrl_reg[bcc_pkg::B_INIT_WIDE];
	assign hold_bus = hold_reg;
	assign target_match = match_reg;
	assign op_accept = accept_reg;
	assign op_split = split_reg;
	assign op_restart = restart_reg;
	assign irq = irq_reg;

endmodule

/* File: bcc_checker.sv */
// Checker: port assertions for the control word block
`timescale 1ns/100ps
module bcc_checker (
	// Clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// Events
	input wire logic        addr_seen,
	input wire logic        addr_general_call,
	input wire logic        rx_queue_full,
	input wire logic        op_req,
	// Outputs
	input wire logic        master_on,
	input wire logic        target_on,
	input wire logic [1:0]  speed_sel,
	input wire logic        initiator_wide,
	input wire logic        hold_bus,
	input wire logic        target_match,
	input wire logic        op_accept,
	input wire logic        op_split,
	input wire logic        op_restart
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_locked_wr;
		reg_wr && reg_addr == bcc_pkg::OFS_CONTROL && (master_on || target_on);
	endsequence
	sequence s_ctl_rd;
		reg_rd && reg_addr == bcc_pkg::OFS_CONTROL;
	endsequence
	chk_locked_write: assert property (s_locked_wr |=> $stable(speed_sel) && $stable(initiator_wide))
		else $error("control word changed while enabled");
	chk_upper_zero: assert property (s_ctl_rd ##1 1'b1 |-> reg_rdata[31:10] == 22'h0)
		else $error("read-only control bits not zero");
	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside read cycle");
	chk_speed_legal: assert property (speed_sel == 2'h1 || speed_sel == 2'h2)
		else $error("illegal speed code");
	chk_gc_nomatch: assert property (addr_seen && addr_general_call |=> !target_match)
		else $error("general call matched");
	chk_off_nomatch: assert property (addr_seen && !target_on |=> !target_match)
		else $error("match with target off");
	chk_match_cause: assert property (target_match |-> $past(addr_seen))
		else $error("match without address");
	chk_op_cause: assert property (op_accept |-> $past(op_req) && $past(master_on))
		else $error("accept without request");
	chk_split_pair: assert property (op_split || op_restart |-> op_accept && !(op_split && op_restart))
		else $error("split and restart mismatch");
	chk_hold_cause: assert property (hold_bus |-> $past(rx_queue_full))
		else $error("hold without full queue");
endmodule
bind bcc_ctrl bcc_checker bcc_checker_inst (.clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
	.addr_seen, .addr_general_call, .rx_queue_full, .op_req, .master_on, .target_on, .speed_sel,
	.initiator_wide, .hold_bus, .target_match, .op_accept, .op_split, .op_restart);

/* File: bcc_line_model.sv */
// Line engine model: bus events, queue levels and master requests
`timescale 1ns/100ps
module bcc_line_model (
	// Clock
	input  wire logic  clk,
	// Bus events
	output logic       stop_seen,
	output logic       addr_seen,
	output logic       addr_is_wide,
	output logic [9:0] addr_value,
	output logic       addr_general_call,
	// Queue state
	output logic       rx_push,
	output logic       rx_queue_full,
	// Master requests
	output logic       op_req,
	output logic [3:0] op_kind
);
	initial begin
		{stop_seen, addr_seen, addr_is_wide, addr_general_call, rx_push} = 5'h0;
		{rx_queue_full, op_req, op_kind, addr_value} = 16'h0;
	end
	task automatic addr(input logic [9:0] v, input logic w, input logic g);
		@(posedge clk);
		addr_seen <= 1'b1;
		addr_value <= v;
		addr_is_wide <= w;
		addr_general_call <= g;
		@(posedge clk);
		addr_seen <= 1'b0;
		addr_value <= ~v;
		addr_is_wide <= ~w;
	endtask
	task automatic op(input logic [3:0] k);
		@(posedge clk);
		op_req <= 1'b1;
		op_kind <= k;
		@(posedge clk);
		op_req <= 1'b0;
		op_kind <= ~k;
	endtask
	task automatic level(input logic f);
		@(posedge clk);
		rx_queue_full <= f;
	endtask
	task automatic pulse(input int w);
		@(posedge clk);
		if (w == 0) stop_seen <= 1'b1;
		else rx_push <= 1'b1;
		@(posedge clk);
		stop_seen <= 1'b0;
		rx_push <= 1'b0;
	endtask
endmodule

/* File: bcc_ctrl_test.sv */
// Testbench: control word, target matching, operations and interrupts
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module bcc_ctrl_test;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata, d;
	logic        stop_seen, addr_seen, addr_is_wide, addr_general_call, rx_push, rx_full, op_req;
	logic [9:0]  addr_value;
	logic [3:0]  k;
	logic        master_on, target_on, initiator_wide, hold_bus, target_match;
	logic        op_accept, op_split, op_restart, irq;
	logic [1:0]  speed_sel;
	logic        busy = 1'b0, tx_empty = 1'b1, tx_idle = 1'b0;
	int          failures = 0;
	int          checks = 0;
	int          m, v;
	always #25 clk = ~clk;
	bcc_line_model bcc_line_model_inst (.clk(clk), .stop_seen(stop_seen), .addr_seen(addr_seen),
		.addr_is_wide(addr_is_wide), .addr_value(addr_value), .addr_general_call(addr_general_call),
		.rx_push(rx_push), .rx_queue_full(rx_full), .op_req(op_req), .op_kind(k));
	bcc_ctrl bcc_ctrl_inst (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_seen(stop_seen),
		.master_busy(busy), .addr_seen(addr_seen), .addr_is_wide(addr_is_wide),
		.addr_value(addr_value), .addr_general_call(addr_general_call), .rx_push(rx_push),
		.rx_queue_full(rx_full), .tx_queue_empty(tx_empty), .tx_idle(tx_idle), .op_req(op_req),
		.op_start_byte(k[3]), .op_high_speed(k[2]), .op_wide_read(k[1]), .op_combined(k[0]),
		.master_on(master_on), .target_on(target_on), .speed_sel(speed_sel),
		.initiator_wide(initiator_wide), .hold_bus(hold_bus), .target_match(target_match),
		.op_accept(op_accept), .op_split(op_split), .op_restart(op_restart), .irq(irq));
	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= x;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Software model of the control word write
	function automatic int fix(input int x);
		x = x & 'h3ff;
		if (x[2:1] == 2'h0 || x[2:1] == 2'h3) x = (x & ~'h6) | 'h4;
		return x;
	endfunction
	task automatic cfg(input int x);
		wr(8'h6c, 32'h0);
		wr(8'h00, x);
		m = fix(x);
		wr(8'h6c, 32'h1);
		@(posedge clk);
		#1;
	endtask
	task automatic close_out;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(50 * 5000);
		failures++;
		close_out();
	end
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		v = $urandom(32'h379a);
		rd(8'h00);
		`CHK(d, 32'h65)
		rd(8'h04);
		`CHK(d, 32'h0)
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? -1 : (i == 1) ? 0 : $urandom;
			v[0] = v[0] & v[6];
			wr(8'h00, v);
			m = fix(v);
			rd(8'h00);
			`CHK(d, m)
			`CHK(speed_sel, m[2:1])
			`CHK(initiator_wide, m[4])
		end
		$display("test 1 done");
		cfg('h41);
		wr(8'h00, 'h3ba);
		rd(8'h00);
		`CHK(d, m)
		for (int i = 1; i < 4; i++) begin
			bcc_line_model_inst.op(4'h1 << i);
			#1 `CHK(op_accept, 1'b0)
			rd(8'h34);
			`CHK(d[6], 1'b1)
			wr(8'h34, 32'h40);
		end
		bcc_line_model_inst.op(4'h1);
		#1 `CHK({op_accept, op_split, op_restart}, 3'h6)
		cfg('h65);
		bcc_line_model_inst.op(4'h9);
		#1 `CHK({op_accept, op_split, op_restart}, 3'h5)
		$display("test 2 done");
		wr(8'h30, 32'h200);
		cfg('ha4);
		`CHK(target_on, 1'b1)
		bcc_line_model_inst.pulse(0);
		#1 `CHK(irq, 1'b0)
		bcc_line_model_inst.addr(10'h055, 1'b0, 1'b1);
		#1 `CHK(target_match, 1'b0)
		bcc_line_model_inst.pulse(0);
		#1 `CHK(irq, 1'b0)
		bcc_line_model_inst.addr(10'h055, 1'b1, 1'b0);
		#1 `CHK(target_match, 1'b0)
		bcc_line_model_inst.addr(10'h355, 1'b0, 1'b0);
		#1 `CHK(target_match, 1'b1)
		bcc_line_model_inst.pulse(0);
		#1 `CHK(irq, 1'b1)
		wr(8'h34, 32'h200);
		`CHK(irq, 1'b0)
		cfg('hac);
		for (int i = 0; i < 3; i++) begin
			bcc_line_model_inst.addr(i == 1 ? 10'h155 : 10'h055, i != 2, 1'b0);
			#1 `CHK(target_match, i == 0)
		end
		$display("test 3 done");
		cfg('h265);
		bcc_line_model_inst.level(1'b1);
		repeat (2) @(posedge clk);
		#1 `CHK(hold_bus, 1'b1)
		cfg('h65);
		`CHK(hold_bus, 1'b0)
		wr(8'h30, 32'h0);
		bcc_line_model_inst.pulse(1);
		#1 `CHK(irq, 1'b0)
		rd(8'h34);
		`CHK(d & 32'h12, 32'h12)
		wr(8'h30, 32'h2);
		@(posedge clk);
		#1 `CHK(irq, 1'b1)
		bcc_line_model_inst.level(1'b0);
		wr(8'h34, 32'h2);
		`CHK(irq, 1'b0)
		wr(8'h30, 32'h200);
		bcc_line_model_inst.pulse(0);
		#1 `CHK(irq, 1'b0)
		@(posedge clk);
		busy <= 1'b1;
		bcc_line_model_inst.pulse(0);
		#1 `CHK(irq, 1'b1)
		@(posedge clk);
		busy <= 1'b0;
		wr(8'h34, 32'h200);
		`CHK(irq, 1'b0)
		cfg('h165);
		@(posedge clk);
		tx_empty <= 1'b0;
		tx_idle <= 1'b1;
		wr(8'h34, 32'h10);
		rd(8'h34);
		`CHK(d[4], 1'b0)
		@(posedge clk);
		tx_empty <= 1'b1;
		tx_idle <= 1'b0;
		wr(8'h34, 32'h10);
		rd(8'h34);
		`CHK(d[4], 1'b0)
		@(posedge clk);
		tx_idle <= 1'b1;
		rd(8'h34);
		`CHK(d[4], 1'b1)
		$display("test 4 done");
		close_out();
	end
endmodule
